// [hdl/dsr_edge_detect.sv]
`timescale 1ns/1ps
module dsr_edge_detect
(
  input wire logic core_clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic level_in, // level to watch
  output logic change // one-cycle pulse on any change
);
  logic prev;
  logic seen;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      prev <= 1'b0;
      seen <= 1'b0;
    end
    else
    begin
      prev <= level_in;
      seen <= 1'b1;
    end
  end
  // no change reported on the first sample after reset
  assign change = seen & (prev ^ level_in);
endmodule // dsr_edge_detect

// [hdl/dsr_pkg.sv]
package dsr_pkg;
  localparam int DSR_AW = 7;
  localparam int DSR_DW = 8;
  localparam int DSR_FW = 19;
  localparam logic [DSR_AW-1:0] DSR_FREQ_HIGH_ADDR = 7'h07;
  localparam logic [DSR_AW-1:0] DSR_IRQ_UPPER_ADDR = 7'h08;
  localparam logic [DSR_AW-1:0] DSR_OPER_STATE_ADDR = 7'h09;
  localparam logic [DSR_DW-1:0] DSR_FREQ_HIGH_RST = 8'h00;
  localparam logic [DSR_DW-1:0] DSR_IRQ_UPPER_RST = 8'h50;
  localparam logic [DSR_DW-1:0] DSR_OPER_STATE_RST = 8'h41;
  localparam int DSR_FREQ_MSB = 18;
  localparam int DSR_FREQ_LSB = 16;
  localparam int DSR_AUX_FLAG_BIT = 6;
  localparam int DSR_PATH_SEL_BIT = 4;
  localparam logic [DSR_DW-1:0] DSR_IRQ_FIXED = 8'h10;
endpackage

// [hdl/dsr_status_regs.sv]
// Contract
// R01: frequency-high register shows frequency bits 18..16 in its bits 2..0.
// R02: select bit 4 chooses main or auxiliary path frequency for reporting.
// R03: auxiliary lock gained or lost sets bit 6 of the upper interrupt byte.
// R04: flag stays latched until software writes one; writing one clears it.
// R05: flag reads zero when no lock change occurred since last clear; the code resets the flag to one.
// R06: read-only operating-state register, reset value 0100 0001.
// R07: writes to read-only registers, unused bits, or zero to flag ignored.
`timescale 1ns/1ps
module dsr_status_regs
(
  input wire logic core_clk, // system clock, 20 MHz
  input wire logic rst_n, // sync reset, active low
  input wire logic [dsr_pkg::DSR_AW-1:0] reg_addr, // register address
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [dsr_pkg::DSR_DW-1:0] reg_wdata, // write data
  output logic [dsr_pkg::DSR_DW-1:0] reg_rdata, // read data, one cycle after reg_rd
  input wire logic [dsr_pkg::DSR_FW-1:0] main_freq, // main timing path frequency word
  input wire logic [dsr_pkg::DSR_FW-1:0] aux_freq, // aux timing path frequency word
  input wire logic freq_path_select, // 1: aux path reported
  input wire logic aux_dpll_locked, // aux timing path lock level
  input wire logic [dsr_pkg::DSR_DW-1:0] mode_state, // mode state machine state
  output logic aux_lock_change_flag // latched lock-change flag
);
  import dsr_pkg::*;

  localparam int FREQ_BITS = DSR_FREQ_MSB - DSR_FREQ_LSB + 1;
  localparam logic [DSR_DW-1:0] FLAG_MASK = {{(DSR_DW-1){1'b0}}, 1'b1} << DSR_AUX_FLAG_BIT;

  ////////////////////////////////////////////////////////////////////////////
  logic [DSR_DW-1:0] dpll_freq_high;
  logic [DSR_DW-1:0] operating_state;
  logic aux_change;
  logic hit_freq;
  logic hit_irq;
  logic hit_oper;
  logic hit_none;
  logic clear_flag;
  logic next_flag;
  logic [DSR_FW-1:0] sel_freq;
  logic [FREQ_BITS-1:0] sel_freq_top;
  logic [DSR_DW-1:0] next_freq_high;
  logic [DSR_DW-1:0] flag_field;
  logic [DSR_DW-1:0] irq_status_upper_byte;
  logic [DSR_DW-1:0] next_rdata;

  dsr_edge_detect u_aux_edge
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .level_in(aux_dpll_locked),
    .change(aux_change)
  );

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  assign hit_freq = (reg_addr == DSR_FREQ_HIGH_ADDR);
  assign hit_irq = (reg_addr == DSR_IRQ_UPPER_ADDR);
  assign hit_oper = (reg_addr == DSR_OPER_STATE_ADDR);
  assign hit_none = ~(hit_freq | hit_irq | hit_oper);

  assign sel_freq = freq_path_select ? aux_freq : main_freq; // [R02]
  assign sel_freq_top = sel_freq[DSR_FREQ_MSB:DSR_FREQ_LSB]; // [R01]
  assign next_freq_high = {{(DSR_DW-FREQ_BITS){1'b0}}, sel_freq_top}; // [R01]

  // set wins over clear so a change in the clearing cycle is kept
  assign clear_flag = reg_wr && hit_irq && reg_wdata[DSR_AUX_FLAG_BIT]; // [R04] [R07]
  assign next_flag = aux_change | (aux_lock_change_flag & ~clear_flag); // [R03] [R04] [R05]
  assign flag_field = {DSR_DW{aux_lock_change_flag}} & FLAG_MASK;
  assign irq_status_upper_byte = DSR_IRQ_FIXED | flag_field;

  assign next_rdata = ({DSR_DW{hit_freq}} & dpll_freq_high) |
                      ({DSR_DW{hit_irq}} & irq_status_upper_byte) |
                      ({DSR_DW{hit_oper}} & operating_state); // [R07]

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      dpll_freq_high <= DSR_FREQ_HIGH_RST;
    else
      dpll_freq_high <= next_freq_high; // [R01] [R07]
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      operating_state <= DSR_OPER_STATE_RST; // [R06]
    else
      operating_state <= mode_state; // [R06] [R07]
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      aux_lock_change_flag <= DSR_IRQ_UPPER_RST[DSR_AUX_FLAG_BIT]; // [R04]
    else
      aux_lock_change_flag <= next_flag; // [R04]
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      reg_rdata <= {DSR_DW{1'b0}};
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock-change flag
  flag_set_a: assert property ( // [R03]
    @(posedge core_clk) disable iff (!rst_n)
    aux_change
    |=> aux_lock_change_flag
  ) else $error("lock change not latched");

  flag_hold_a: assert property ( // [R04]
    @(posedge core_clk) disable iff (!rst_n)
    aux_lock_change_flag && !clear_flag
    |=> aux_lock_change_flag
  ) else $error("flag dropped");

  flag_clear_a: assert property ( // [R04]
    @(posedge core_clk) disable iff (!rst_n)
    clear_flag && !aux_change
    |=> !aux_lock_change_flag
  ) else $error("flag not cleared");

  set_wins_a: assert property ( // [R04]
    @(posedge core_clk) disable iff (!rst_n)
    clear_flag && aux_change
    |=> aux_lock_change_flag
  ) else $error("change lost to clear");

  flag_quiet_a: assert property ( // [R05]
    @(posedge core_clk) disable iff (!rst_n)
    !aux_lock_change_flag && !aux_change
    |=> !aux_lock_change_flag
  ) else $error("spurious flag");

  flag_reset_a: assert property ( // [R04]
    @(posedge core_clk)
    !rst_n
    |=> aux_lock_change_flag == DSR_IRQ_UPPER_RST[DSR_AUX_FLAG_BIT]
  ) else $error("flag reset wrong");

  zero_write_a: assert property ( // [R07]
    @(posedge core_clk) disable iff (!rst_n)
    reg_wr && hit_irq && !reg_wdata[DSR_AUX_FLAG_BIT] && aux_lock_change_flag
    |=> aux_lock_change_flag
  ) else $error("zero write cleared flag");

  // frequency
  freq_main_a: assert property ( // [R01]
    @(posedge core_clk) disable iff (!rst_n)
    !freq_path_select
    |=> dpll_freq_high == {{(DSR_DW-FREQ_BITS){1'b0}}, $past(main_freq[DSR_FREQ_MSB:DSR_FREQ_LSB])}
  ) else $error("main freq wrong");

  freq_aux_a: assert property ( // [R02]
    @(posedge core_clk) disable iff (!rst_n)
    freq_path_select
    |=> dpll_freq_high == {{(DSR_DW-FREQ_BITS){1'b0}}, $past(aux_freq[DSR_FREQ_MSB:DSR_FREQ_LSB])}
  ) else $error("aux freq wrong");

  freq_reset_a: assert property ( // [R01]
    @(posedge core_clk)
    !rst_n
    |=> dpll_freq_high == DSR_FREQ_HIGH_RST
  ) else $error("freq reset wrong");

  freq_ro_a: assert property ( // [R07]
    @(posedge core_clk) disable iff (!rst_n)
    reg_wr && hit_freq
    |=> dpll_freq_high[DSR_DW-1:FREQ_BITS] == {(DSR_DW-FREQ_BITS){1'b0}}
  ) else $error("write hit freq register");

  // operating state
  oper_reset_a: assert property ( // [R06]
    @(posedge core_clk)
    !rst_n
    |=> operating_state == DSR_OPER_STATE_RST
  ) else $error("operating reset wrong");

  oper_follow_a: assert property ( // [R06]
    @(posedge core_clk) disable iff (!rst_n)
    rst_n
    |=> operating_state == $past(mode_state)
  ) else $error("operating state stale");

  ro_write_a: assert property ( // [R07]
    @(posedge core_clk) disable iff (!rst_n)
    reg_wr && hit_oper
    |=> operating_state == $past(mode_state)
  ) else $error("write hit read-only");

  // read path
  read_freq_a: assert property ( // [R01]
    @(posedge core_clk) disable iff (!rst_n)
    reg_rd && hit_freq
    |=> reg_rdata == $past(dpll_freq_high)
  ) else $error("freq read wrong");

  read_irq_a: assert property ( // [R05]
    @(posedge core_clk) disable iff (!rst_n)
    reg_rd && hit_irq
    |=> reg_rdata[DSR_AUX_FLAG_BIT] == $past(aux_lock_change_flag)
  ) else $error("flag read wrong");

  read_fixed_a: assert property ( // [R07]
    @(posedge core_clk) disable iff (!rst_n)
    reg_rd && hit_irq
    |=> (reg_rdata & ~FLAG_MASK) == (DSR_IRQ_FIXED & ~FLAG_MASK)
  ) else $error("unused irq bits wrong");

  read_oper_a: assert property ( // [R06]
    @(posedge core_clk) disable iff (!rst_n)
    reg_rd && hit_oper
    |=> reg_rdata == $past(operating_state)
  ) else $error("operating read wrong");

  read_none_a: assert property ( // [R07]
    @(posedge core_clk) disable iff (!rst_n)
    reg_rd && hit_none
    |=> reg_rdata == {DSR_DW{1'b0}}
  ) else $error("unmapped read not zero");
endmodule // dsr_status_regs

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import dsr_pkg::*;
  logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, freq_path_select = 0, aux_dpll_locked = 0;
  logic [DSR_AW-1:0] reg_addr = '0;
  logic [DSR_DW-1:0] reg_wdata = '0, mode_state = 8'hA5, reg_rdata;
  logic [DSR_FW-1:0] main_freq = 19'h50000, aux_freq = 19'h2FFFF;
  logic aux_lock_change_flag;
  int num_errors = 0, total_checks = 0, cycles = 0;
  dsr_status_regs dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .main_freq(main_freq), .aux_freq(aux_freq),
    .freq_path_select(freq_path_select), .aux_dpll_locked(aux_dpll_locked), .mode_state(mode_state),
    .aux_lock_change_flag(aux_lock_change_flag));
  initial forever #25 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(negedge core_clk) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge core_clk) reg_rd = 0;
    check(reg_rdata, exp);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge core_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge core_clk) reg_wr = 0;
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rst_n = 0;
    repeat (12) @(negedge core_clk);
    check(aux_lock_change_flag, 8'h01);
    // first request at the first edge after release sees the reset value
    {rst_n, reg_rd, reg_addr} = {1'b1, 1'b1, DSR_OPER_STATE_ADDR};
    @(negedge core_clk) reg_rd = 0;
    check(reg_rdata, 8'h41);
    $display("reset test done");
  endtask
  task automatic t_freq();
    rd(DSR_FREQ_HIGH_ADDR, 8'h05);
    wr(DSR_FREQ_HIGH_ADDR, 8'hFF);
    rd(DSR_FREQ_HIGH_ADDR, 8'h05);
    freq_path_select = 1;
    rd(DSR_FREQ_HIGH_ADDR, 8'h02);
    freq_path_select = 0;
    rd(DSR_FREQ_HIGH_ADDR, 8'h05);
    $display("freq test done");
  endtask
  task automatic t_flag();
    check(aux_lock_change_flag, 8'h01);
    rd(DSR_IRQ_UPPER_ADDR, 8'h50);
    wr(DSR_IRQ_UPPER_ADDR, 8'hBF);
    check(aux_lock_change_flag, 8'h01);
    wr(DSR_IRQ_UPPER_ADDR, 8'h40);
    rd(DSR_IRQ_UPPER_ADDR, 8'h10);
    aux_dpll_locked = 1;
    repeat (3) @(negedge core_clk);
    rd(DSR_IRQ_UPPER_ADDR, 8'h50);
    wr(DSR_IRQ_UPPER_ADDR, 8'h40);
    rd(DSR_IRQ_UPPER_ADDR, 8'h10);
    aux_dpll_locked = 0;
    repeat (3) @(negedge core_clk);
    check(aux_lock_change_flag, 8'h01);
    wr(DSR_IRQ_UPPER_ADDR, 8'h40);
    check(aux_lock_change_flag, 8'h00);
    // lock change and clear in one cycle: the change is kept
    @(negedge core_clk) {aux_dpll_locked, reg_wr, reg_addr, reg_wdata} = {1'b1, 1'b1, DSR_IRQ_UPPER_ADDR, 8'h40};
    @(negedge core_clk) reg_wr = 0;
    check(aux_lock_change_flag, 8'h01);
    wr(DSR_IRQ_UPPER_ADDR, 8'h40);
    repeat (3) @(negedge core_clk);
    check(aux_lock_change_flag, 8'h00);
    $display("flag test done");
  endtask
  task automatic t_oper();
    rd(DSR_OPER_STATE_ADDR, 8'hA5);
    mode_state = 8'h3C;
    wr(DSR_OPER_STATE_ADDR, 8'h00);
    rd(DSR_OPER_STATE_ADDR, 8'h3C);
    rd(7'h7F, 8'h00);
    $display("oper test done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      finish_test();
    end
  end
  initial
  begin
    t_reset();
    t_freq();
    t_flag();
    t_oper();
    t_reset();
    finish_test();
  end
endmodule // tb_top
